// [logic/irq_status_aggregator.sv]
// common interrupt status register with active-low interrupt line to the host
// assumes the host reaches it directly or through the indirect address window,
// and that the socket logic reports which socket event registers hold a nonzero value
`timescale 1ns/10ps
`default_nettype none
// guarded, so the package pulling it in as well does no harm
`include "irq_params.svh"

module irq_status_aggregator #(
    parameter int SOCKETS = `SOCKET_COUNT
) (
    input wire logic clock_in, // device clock, 50 MHz
    input wire logic rst_in, // synchronous reset, active high
    input wire logic indirect_mode_in, // 1: indirect address mode
    input wire logic pppoe_mode_in, // 1: PPPoE mode enabled
    input wire logic [31:0] own_ip_in, // device source IP address
    input wire logic [15:0] interrupt_enable_bits_in, // mask, one bit per status bit
    input wire logic [SOCKETS-1:0] socket_event_register_nonzero_in, // per-socket register holds a set bit
    input wire irq_pkg::net_events_t events_in, // event strobes
    input wire irq_pkg::host_req_t host_req_in, // host register access
    output logic [15:0] read_data_out, // read data, valid with ack
    output logic ack_out, // one-cycle pulse after a status access
    output logic [15:0] interrupt_status_out, // status register copy
    output logic interrupt_n_out // interrupt to host, active low
);

    generate
        if (SOCKETS != `SOCKET_COUNT) begin : g_bad_sockets
            $error("irq_status_aggregator: SOCKETS must be 8 to fill the lower byte");
        end
    endgenerate

    localparam int ULSB = `UPPER_EVENT_LSB;
    localparam int UCNT = `UPPER_EVENT_COUNT;

    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
        // bit 0 picks a byte lane on 8-bit hosts, so it is ignored here
        return addr[15:1] == ofs[15:1];
    endfunction

    logic [UCNT-1:0] upper_flags;
    logic [UCNT-1:0] upper_set;
    logic [UCNT-1:0] upper_clear;
    logic [SOCKETS-1:0] socket_reg;
    logic [SOCKETS-1:0] socket_next;
    logic [15:0] status;
    // kept in its active-low sense so the pin comes straight from a flop
    logic int_n_reg;
    logic int_active_next;
    logic [15:0] read_data_reg;
    logic ack_reg;
    logic status_hit;
    logic status_write;
    logic status_read;
    logic conflict_event;

    assign status_hit = indirect_mode_in ? addr_hit(host_req_in.addr, `STATUS_OFS_INDIRECT)
                                         : addr_hit(host_req_in.addr, `STATUS_OFS_DIRECT);
    // a write that enables neither byte lane is no access at all
    assign status_write = status_hit & host_req_in.wr & (host_req_in.be_hi | host_req_in.be_lo);
    assign status_read = status_hit & host_req_in.rd;

    assign conflict_event = events_in.arp_request & (events_in.arp_sender_ip == own_ip_in);
    assign upper_set[`BIT_ADDRESS_CONFLICT-ULSB] = conflict_event;
    assign upper_set[`BIT_PORT_UNREACHABLE-ULSB] = events_in.icmp_port_unreachable;
    assign upper_set[`BIT_SESSION_TERMINATED-ULSB] = events_in.session_closed & pppoe_mode_in;
    assign upper_set[`BIT_FRAGMENT_SIZE-ULSB] = events_in.icmp_fragment_needed;

    // only the upper lane carries write-one-to-clear; lower-byte data is ignored
    assign upper_clear = (status_write & host_req_in.be_hi) ? host_req_in.data[15:ULSB] : '0;

    sticky_flag_bank #(
        .WIDTH(UCNT)
    ) u_upper_flags (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .set_in(upper_set),
        .clear_in(upper_clear),
        .flags_out(upper_flags)
    );

    // the summary follows the socket register, host writes cannot touch it
    assign socket_next = socket_event_register_nonzero_in;

    // reserved bits are constant zero, so they can neither read back nor interrupt
    assign status = {upper_flags, 4'h0, socket_reg};

    // once low the line waits for every status bit, not only the enabled ones
    assign int_active_next = (|(status & interrupt_enable_bits_in)) | (~int_n_reg & (|status));

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            socket_reg <= '0;
            int_n_reg <= `INTERRUPT_N_RESET;
            read_data_reg <= `READ_DATA_RESET;
            ack_reg <= 1'b0;
        end else begin
            socket_reg <= socket_next;
            int_n_reg <= ~int_active_next;
            ack_reg <= status_read | status_write;
            if (status_read) begin
                read_data_reg <= status;
            end
        end
    end

    assign read_data_out = read_data_reg;
    assign ack_out = ack_reg;
    assign interrupt_status_out = status;
    assign interrupt_n_out = int_n_reg;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_event_sets_bit: assert property (
        events_in.icmp_port_unreachable |=> status[`BIT_PORT_UNREACHABLE])
        else $error("port unreachable event did not set its bit");

    a_conflict_sets_bit: assert property (
        conflict_event |=> status[`BIT_ADDRESS_CONFLICT])
        else $error("address conflict did not set bit 15");

    a_session_pppoe_only: assert property (
        (events_in.session_closed & ~pppoe_mode_in & ~status[`BIT_SESSION_TERMINATED])
        |=> ~status[`BIT_SESSION_TERMINATED])
        else $error("session bit set outside PPPoE mode");

    a_fragment_sets_bit: assert property (
        events_in.icmp_fragment_needed |=> status[`BIT_FRAGMENT_SIZE])
        else $error("fragment notice did not set bit 12");

    a_clear_upper_bit: assert property (
        (status_write & host_req_in.be_hi & host_req_in.data[`BIT_PORT_UNREACHABLE]
         & ~events_in.icmp_port_unreachable) |=> ~status[`BIT_PORT_UNREACHABLE])
        else $error("write of one did not clear the upper bit");

    a_zero_write_keeps: assert property (
        (status_write & status[`BIT_FRAGMENT_SIZE] & ~host_req_in.data[`BIT_FRAGMENT_SIZE])
        |=> status[`BIT_FRAGMENT_SIZE])
        else $error("writing zero changed an upper bit");

    a_socket_follows: assert property (
        ##1 status[SOCKETS-1:0] == $past(socket_event_register_nonzero_in))
        else $error("socket summary bits do not follow socket registers");

    a_reserved_zero: assert property (
        status[11:8] == 4'h0)
        else $error("reserved status bits not zero");

    a_int_asserts: assert property (
        (|(status & interrupt_enable_bits_in)) |=> ~interrupt_n_out)
        else $error("enabled set bit did not pull the interrupt low");

    a_int_holds_low: assert property (
        (~interrupt_n_out & (|status)) |=> ~interrupt_n_out)
        else $error("interrupt released while status bits remain");

    a_int_quiet_masked: assert property (
        (interrupt_n_out & ~(|(status & interrupt_enable_bits_in))) |=> interrupt_n_out)
        else $error("interrupt fell with no enabled status bit");

    a_reset_zero: assert property (
        @(posedge clock_in) disable iff (1'b0) $past(rst_in) |-> (status == `STATUS_RESET && interrupt_n_out))
        else $error("status or interrupt not cleared by reset");

    a_int_releases: assert property (
        (~interrupt_n_out & ~(|status)) |=> interrupt_n_out)
        else $error("interrupt stayed low with all status bits zero");

    a_session_sets_bit: assert property (
        (events_in.session_closed & pppoe_mode_in) |=> status[`BIT_SESSION_TERMINATED])
        else $error("session end in PPPoE mode did not set bit 13");

    a_conflict_only_own: assert property (
        (~conflict_event & ~status[`BIT_ADDRESS_CONFLICT]) |=> ~status[`BIT_ADDRESS_CONFLICT])
        else $error("bit 15 set without an own-address request");

    a_lane_needed: assert property (
        (status_write & ~host_req_in.be_hi & status[`BIT_FRAGMENT_SIZE]) |=> status[`BIT_FRAGMENT_SIZE])
        else $error("write without the upper lane cleared a flag");

    a_ack_follows: assert property (
        (status_read | status_write) |=> ack_out)
        else $error("taken status access was not acknowledged");

    a_ack_quiet: assert property (
        ~(status_read | status_write) |=> ~ack_out)
        else $error("acknowledge without a status access");

    a_read_captures: assert property (
        status_read |=> (read_data_out == $past(status)))
        else $error("read data differs from the status it sampled");

    a_read_data_holds: assert property (
        ~status_read |=> $stable(read_data_out))
        else $error("read data changed without a status read");

    c_int_cycle: cover property (~interrupt_n_out ##[1:20] interrupt_n_out);
    c_clear_write: cover property (status_write & (|upper_clear));
    c_set_and_clear: cover property (|(upper_set & upper_clear));
    c_indirect_read: cover property (status_read & indirect_mode_in);
    c_session_set: cover property (events_in.session_closed & pppoe_mode_in);

endmodule

`default_nettype wire

// [logic/irq_params.svh]
// constants of the common interrupt status logic: offsets, bit positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define STATUS_OFS_INDIRECT 16'h0002
`define STATUS_OFS_DIRECT 16'h8002
`define STATUS_RESET 16'h0000
`define ENABLE_BITS_RESET 16'h0000
`define BIT_ADDRESS_CONFLICT 15
`define BIT_PORT_UNREACHABLE 14
`define BIT_SESSION_TERMINATED 13
`define BIT_FRAGMENT_SIZE 12
`define UPPER_EVENT_LSB 12
`define UPPER_EVENT_COUNT 4
`define SOCKET_COUNT 8
`define UPPER_BYTE_LSB 8
`define READ_DATA_RESET 16'h0000
`define INTERRUPT_N_RESET 1'b1

`endif

// [logic/irq_pkg.sv]
// types shared by the interrupt status logic and the host model
// assumes irq_params.svh is on the include path
`include "irq_params.svh"

package irq_pkg;

    // one parallel host bus access; byte enables select lanes on an 8-bit host bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] data;
        logic be_hi;
        logic be_lo;
    } host_req_t;

    // one-cycle event strobes from the packet logic
    typedef struct packed {
        logic arp_request;
        logic [31:0] arp_sender_ip;
        logic icmp_port_unreachable;
        logic session_closed;
        logic icmp_fragment_needed;
    } net_events_t;

endpackage

// [logic/sticky_flag_bank.sv]
// bank of sticky flags: set by hardware strobes, cleared by write-one from the host
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
`include "irq_params.svh"

module sticky_flag_bank #(
    parameter int WIDTH = `UPPER_EVENT_COUNT
) (
    input wire logic clock_in, // device clock
    input wire logic rst_in, // synchronous reset, active high
    input wire logic [WIDTH-1:0] set_in, // event strobes
    input wire logic [WIDTH-1:0] clear_in, // write-one-to-clear strobes
    output logic [WIDTH-1:0] flags_out // sticky flags
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sticky_flag_bank: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // a set in the clearing cycle survives, writing zero changes nothing
    assign flags_next = set_in | (flags_reg & ~clear_in);
    assign flags_out = flags_reg;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    a_set_wins_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        |set_in |=> ((flags_reg & $past(set_in)) == $past(set_in)))
        else $error("a flag with a pending set did not end up set");

endmodule

`default_nettype wire

// [sim/host_model.sv]
// host processor model: one register access at a time on the parallel bus
// assumes ack and read data arrive one cycle after the request is taken
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clock_in, // device clock
    input wire logic ack_in, // access acknowledge
    input wire logic [15:0] read_data_in, // status read data
    output var irq_pkg::host_req_t req_out // request to the device
);
    initial req_out = '0;
    // a write of ones is the only way the host clears upper flags
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                          output logic ack, output logic [15:0] rdata);
        @(posedge clock_in);
        #1 req_out = '{wr, !wr, addr, data, 1'b1, 1'b1};
        @(posedge clock_in);
        #1 req_out = '0;
        ack = ack_in;
        rdata = read_data_in;
    endtask
endmodule
`default_nettype wire

// [sim/test_common_interrupt_aggregator.sv]
// testbench of the common interrupt status logic with a host model
// assumes every input changes 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module test_common_interrupt_aggregator;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ind = 1'b0;
    logic ppp = 1'b0;
    logic [31:0] ip = 32'h0A000001;
    logic [15:0] mask = 16'h0000;
    logic [7:0] sock = 8'h00;
    logic [15:0] ofs = 16'h8002;
    irq_pkg::net_events_t ev = '0;
    irq_pkg::host_req_t req;
    logic [15:0] rd, st;
    logic ack, int_n;
    int failures = 0;
    int cmp_count = 0;
    always #10 clock_in = ~clock_in;
    irq_status_aggregator dut (.clock_in(clock_in), .rst_in(rst_in), .indirect_mode_in(ind),
        .pppoe_mode_in(ppp), .own_ip_in(ip), .interrupt_enable_bits_in(mask),
        .socket_event_register_nonzero_in(sock), .events_in(ev), .host_req_in(req),
        .read_data_out(rd), .ack_out(ack), .interrupt_status_out(st), .interrupt_n_out(int_n));
    host_model host (.clock_in(clock_in), .ack_in(ack), .read_data_in(rd), .req_out(req));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick;
        @(posedge clock_in);
        #1;
    endtask
    // access at any address; ack is expected exactly when it hits the active offset
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
        logic k;
        logic [15:0] r;
        host.access(wr, a, d, k, r);
        chk("ack", {15'h0000, a[15:1] == ofs[15:1]}, {15'h0000, k});
        if (!wr)
            chk("read", exp, r);
    endtask
    task automatic strobe(input logic [3:0] v, input logic [31:0] who);
        ev = '{v[3], who, v[2], v[1], v[0]};
        tick();
        ev = '0;
    endtask
    task automatic s_reset;
        chk("status", 16'h0000, st);
        chk("int_n", 16'h0001, {15'h0000, int_n});
        bus(1'b0, 16'h8002, 16'h0000, 16'h0000);
        bus(1'b0, 16'h8004, 16'h0000, 16'h0000);
    endtask
    task automatic s_events;
        strobe(4'b1000, ~ip);
        strobe(4'b0010, ip);
        tick();
        chk("refused", 16'h0000, st);
        ppp = 1'b1;
        strobe(4'b1111, ip);
        chk("events", 16'hF000, st);
        tick();
        chk("masked", 16'h0001, {15'h0000, int_n});
        bus(1'b1, ofs, 16'h0000, 16'h0000);
        chk("zero write", 16'hF000, st);
        bus(1'b1, ofs, 16'h8000, 16'h0000);
        chk("clear15", 16'h7000, st);
        bus(1'b1, ofs, 16'h7F00, 16'h0000);
        chk("clear all", 16'h0000, st);
    endtask
    task automatic s_irq;
        mask = 16'h1000;
        strobe(4'b0001, ip);
        tick();
        chk("int low", 16'h0000, {15'h0000, int_n});
        mask = 16'h0000;
        tick();
        chk("int held", 16'h0000, {15'h0000, int_n});
        bus(1'b1, ofs, 16'h1000, 16'h0000);
        tick();
        chk("int high", 16'h0001, {15'h0000, int_n});
    endtask
    task automatic s_socket;
        ind = 1'b1;
        ofs = 16'h0002;
        sock = 8'hA5;
        tick();
        chk("socket", 16'h00A5, st);
        bus(1'b1, ofs, 16'h0FFF, 16'h0000);
        bus(1'b0, ofs, 16'h0000, 16'h00A5);
        // a refused read leaves the last read data standing
        bus(1'b0, 16'h8002, 16'h0000, 16'h00A5);
        sock = 8'h00;
        tick();
        tick();
        chk("socket clear", 16'h0000, st);
    endtask
    // event and clearing write meet at one edge
    task automatic s_collide;
        logic k;
        logic [15:0] r;
        fork
            host.access(1'b1, ofs, 16'h4000, k, r);
            begin
                @(posedge clock_in);
                #1 ev.icmp_port_unreachable = 1'b1;
                tick();
                ev = '0;
            end
        join
        chk("set beats clear", 16'h4000, st);
        bus(1'b1, ofs, 16'h4000, 16'h0000);
        chk("cleared", 16'h0000, st);
    endtask
    task automatic s_rereset;
        mask = 16'h4000;
        strobe(4'b0100, ip);
        tick();
        chk("int before reset", 16'h0000, {15'h0000, int_n});
        rst_in = 1'b1;
        tick();
        tick();
        rst_in = 1'b0;
        chk("status after reset", 16'h0000, st);
        chk("int after reset", 16'h0001, {15'h0000, int_n});
        mask = 16'h0000;
        bus(1'b0, ofs, 16'h0000, 16'h0000);
    endtask
    // cuts a hang short; the whole run needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        #1 rst_in = 1'b0;
        s_reset();
        s_events();
        s_irq();
        s_socket();
        s_collide();
        s_rereset();
        give_verdict();
    end
endmodule
`default_nettype wire
